// [design/eeprom_ctl_regs.vh]
// timing counts and command step values for the parallel eeprom write controller
// assumes a 50 MHz system clock (20 ns period)
`ifndef EEPROM_CTL_REGS_VH
`define EEPROM_CTL_REGS_VH
`define CLK_PERIOD_NS 20
`define HOLDOFF_MS 10
`define HOLDOFF_CYC ((`HOLDOFF_MS * 1000000) / `CLK_PERIOD_NS)
`define STROBE_NS 100
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS 60
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOAD_WIN_US 100
`define LOAD_WIN_CYC ((`LOAD_WIN_US * 1000) / `CLK_PERIOD_NS)
`define LOAD_GAP_CYC 50
`define ARM_A0 16'h5555
`define ARM_D0 8'hAA
`define ARM_A1 16'h2AAA
`define ARM_D1 8'h55
`define ARM_A2 16'h5555
`define ARM_D2 8'hA0
`define DIS_D2 8'h80
`define DIS_D5 8'h20
`endif

// [design/step_timer.v]
// down counter that pulses done after a loaded number of cycles
// assumes a single clock domain; load restarts the count
`timescale 1ns/10ps
`default_nettype none
module step_timer #(
  parameter W = 20
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire load_i,
  input wire [W-1:0] count_i,
  output reg done_o
);
  reg [W-1:0] cnt_reg;
  reg run_reg;
  // count down while running; done is a one-cycle pulse
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= {W{1'b0}};
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_reg <= count_i;
      run_reg <= 1'b1;
      done_o <= 1'b0;
    end else if (run_reg) begin
      done_o <= (cnt_reg <= {{(W-1){1'b0}}, 1'b1});
      run_reg <= (cnt_reg > {{(W-1){1'b0}}, 1'b1});
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule // step_timer
`default_nettype wire

// [design/eeprom_write_host.v]
// host-side write controller for a byte-wide parallel eeprom with software lock
// assumes supply-good arrives from a pin; the eeprom data bus is a two-way pin
// Functional notes
// - arm with three fixed command writes
// - command and data writes use page timing
// - armed: prefix the first write of each load with arm sequence
// - six writes disarm the lock
// - data follows arming within load window
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_ctl_regs.vh"
module eeprom_write_host #(
  parameter [15:0] ARM_A0 = `ARM_A0,
  parameter [7:0] ARM_D0 = `ARM_D0,
  parameter [15:0] ARM_A1 = `ARM_A1,
  parameter [7:0] ARM_D1 = `ARM_D1,
  parameter [15:0] ARM_A2 = `ARM_A2,
  parameter [7:0] ARM_D2 = `ARM_D2,
  parameter [7:0] DIS_D2 = `DIS_D2,
  parameter [7:0] DIS_D5 = `DIS_D5,
  parameter [22:0] HOLDOFF_CYC = `HOLDOFF_CYC,
  parameter [12:0] LOAD_WIN_CYC = `LOAD_WIN_CYC
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire supply_ok_i,
  input wire req_i,
  input wire [1:0] op_i,
  input wire [15:0] addr_i,
  input wire [7:0] data_i,
  input wire lock_armed_i,
  input wire last_i,
  output reg busy_o,
  output reg done_o,
  output reg ready_o,
  output reg lock_state_o,
  output reg ce_n_o,
  output reg oe_n_o,
  output reg we_n_o,
  output reg [15:0] a_o,
  output reg [7:0] dq_o,
  output reg dq_oe_o
);
  // op codes: 0 plain data write, 1 arm, 2 disarm
  localparam [1:0] OP_WRITE = 2'd0;
  localparam [1:0] OP_ARM = 2'd1;
  localparam [1:0] OP_DISARM = 2'd2;
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_SETUP = 6'b000010;
  localparam [5:0] S_LOW = 6'b000100;
  localparam [5:0] S_HIGH = 6'b001000;
  localparam [5:0] S_WAITREQ = 6'b010000;
  localparam [5:0] S_DRAIN = 6'b100000;
  localparam [22:0] STROBE_CYC = `STROBE_CYC;
  localparam [22:0] SETUP_CYC = `SETUP_CYC;
  localparam [22:0] GAP_CYC = `LOAD_GAP_CYC;

  // command step table: arm is steps 0..2, disarm is six steps
  function [23:0] step_word;
    input disarm;
    input [2:0] idx;
    begin
      case (idx)
        3'd0: step_word = {ARM_A0, ARM_D0};
        3'd1: step_word = {ARM_A1, ARM_D1};
        3'd2: step_word = {ARM_A2, disarm ? DIS_D2 : ARM_D2};
        3'd3: step_word = {ARM_A0, ARM_D0};
        3'd4: step_word = {ARM_A1, ARM_D1};
        default: step_word = {ARM_A2, DIS_D5};
      endcase
    end
  endfunction

  reg sync1_reg, sync2_reg, sync3_reg, supply_reg;
  reg hold_done_reg;
  reg [22:0] hold_cnt_reg;
  reg [5:0] state_reg;
  reg [2:0] step_reg;
  reg [2:0] nsteps_reg;
  reg [1:0] op_reg;
  reg [15:0] addr_reg;
  reg [7:0] data_reg;
  reg last_reg;
  reg armed_reg;
  reg tim_load_reg;
  reg [22:0] tim_count_reg;
  wire tim_done;

  step_timer #(.W(23)) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tim_load_reg),
    .count_i(tim_count_reg),
    .done_o(tim_done)
  );

  // supply sense pin: three flops, change taken once second and third agree
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      supply_reg <= 1'b0;
    end else begin
      sync1_reg <= supply_ok_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg)
        supply_reg <= sync3_reg;
    end
  end

  // holdoff counter restarts whenever supply drops, so a brownout re-arms the wait
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_cnt_reg <= 23'd0;
      hold_done_reg <= 1'b0;
    end else if (!supply_reg) begin
      hold_cnt_reg <= 23'd0;
      hold_done_reg <= 1'b0;
    end else if (!hold_done_reg) begin
      hold_cnt_reg <= hold_cnt_reg + 23'd1;
      hold_done_reg <= (hold_cnt_reg + 23'd1 >= HOLDOFF_CYC);
    end
  end

  // main sequencer: command prefix steps, then the data byte for write ops only, all with page timing
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= S_IDLE;
      step_reg <= 3'd0;
      nsteps_reg <= 3'd0;
      op_reg <= OP_WRITE;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
      last_reg <= 1'b0;
      armed_reg <= 1'b0;
      lock_state_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      ready_o <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      a_o <= 16'h0000;
      dq_o <= 8'h00;
      dq_oe_o <= 1'b0;
      tim_load_reg <= 1'b0;
      tim_count_reg <= 23'd0;
    end else begin
      tim_load_reg <= 1'b0;
      done_o <= 1'b0;
      lock_state_o <= armed_reg;
      ready_o <= (state_reg == S_IDLE) && hold_done_reg && supply_reg;
      case (state_reg)
        S_IDLE: begin
          busy_o <= 1'b0;
          we_n_o <= 1'b1;
          ce_n_o <= 1'b1;
          dq_oe_o <= 1'b0;
          // lock state is held in the part; software tells us the stored state
          armed_reg <= armed_reg | lock_armed_i;
          if (req_i && hold_done_reg && supply_reg && op_i != 2'd3) begin
            op_reg <= op_i;
            addr_reg <= addr_i;
            data_reg <= data_i;
            last_reg <= last_i;
            busy_o <= 1'b1;
            ready_o <= 1'b0; // never show ready and busy together on the take edge
            step_reg <= 3'd0;
            // armed data writes carry the arm prefix; disarm carries six steps
            if (op_i == OP_DISARM)
              nsteps_reg <= 3'd6;
            else if (op_i == OP_ARM || (armed_reg | lock_armed_i))
              nsteps_reg <= 3'd3;
            else
              nsteps_reg <= 3'd0;
            oe_n_o <= 1'b1;
            tim_count_reg <= SETUP_CYC;
            tim_load_reg <= 1'b1;
            state_reg <= S_SETUP;
          end
        end
        S_SETUP: begin
          // drive address and data while strobe is high so both latches see stable bus
          if (step_reg < nsteps_reg)
            {a_o, dq_o} <= step_word(op_reg == OP_DISARM, step_reg);
          else
            {a_o, dq_o} <= {addr_reg, data_reg};
          dq_oe_o <= 1'b1;
          ce_n_o <= 1'b0;
          if (tim_done) begin
            we_n_o <= 1'b0;
            tim_count_reg <= STROBE_CYC;
            tim_load_reg <= 1'b1;
            state_reg <= S_LOW;
          end
        end
        S_LOW: begin
          // strobe held low at least 100 ns, well past the 20 ns glitch filter
          if (tim_done) begin
            we_n_o <= 1'b1;
            tim_count_reg <= GAP_CYC;
            tim_load_reg <= 1'b1;
            state_reg <= S_HIGH;
          end
        end
        S_HIGH: begin
          // short gap keeps the next strobe inside the byte-load window
          if (tim_done) begin
            if (op_reg == OP_ARM && step_reg == 3'd2)
              armed_reg <= 1'b1;
            if (op_reg == OP_DISARM && step_reg == 3'd5)
              armed_reg <= 1'b0;
            if (step_reg < nsteps_reg && op_reg == OP_WRITE) begin
              step_reg <= step_reg + 3'd1;
              state_reg <= S_SETUP;
              tim_count_reg <= SETUP_CYC;
              tim_load_reg <= 1'b1;
            end else if (step_reg + 3'd1 < nsteps_reg) begin
              step_reg <= step_reg + 3'd1;
              state_reg <= S_SETUP;
              tim_count_reg <= SETUP_CYC;
              tim_load_reg <= 1'b1;
            end else if (op_reg == OP_WRITE && !last_reg) begin
              state_reg <= S_WAITREQ;
              ready_o <= 1'b1;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end else begin
              ce_n_o <= 1'b1;
              dq_oe_o <= 1'b0;
              tim_count_reg <= {10'd0, LOAD_WIN_CYC} + 23'd1;
              tim_load_reg <= 1'b1;
              state_reg <= S_DRAIN;
            end
          end
        end
        S_WAITREQ: begin
          // next page byte: no prefix inside the same load; drain if host is late
          ready_o <= 1'b1;
          if (req_i && op_i == OP_WRITE && supply_reg) begin
            addr_reg <= addr_i;
            data_reg <= data_i;
            last_reg <= last_i;
            nsteps_reg <= 3'd0;
            step_reg <= 3'd0;
            busy_o <= 1'b1;
            ready_o <= 1'b0;
            tim_count_reg <= SETUP_CYC;
            tim_load_reg <= 1'b1;
            state_reg <= S_SETUP;
          end else begin
            ready_o <= 1'b0;
            ce_n_o <= 1'b1;
            dq_oe_o <= 1'b0;
            busy_o <= 1'b1;
            tim_count_reg <= {10'd0, LOAD_WIN_CYC} + 23'd1;
            tim_load_reg <= 1'b1;
            state_reg <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          // strobe stays high past the load window so programming starts;
          // status reads are left to software and edge toggle reads are not trusted
          if (tim_done) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // eeprom_write_host
`default_nettype wire

// [verification/eeprom_model.sv]
// behavioural eeprom seen by the host: byte array plus the software write lock
// assumes host-driven strobes; the lock is never cleared by a host reset
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_ctl_regs.vh"
module eeprom_model #(
  parameter realtime WIN = 2000.0
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [15:0] a_i,
  input wire logic [7:0] dq_i // write-only view: no status reads, toggle bit never trusted
);
  logic [7:0] mem [0:65535];
  logic [15:0] al;
  logic locked = 1'b0;
  logic ok = 1'b0;
  int step = 0;
  int rej = 0;
  realtime tf = 0.0;
  realtime tr = 0.0;
  // expected command step; step 2 also takes the disarm branch value
  wire logic [15:0] ea = (step % 3 == 0) ? `ARM_A0 : (step % 3 == 1) ? `ARM_A1 : `ARM_A2;
  wire logic [7:0] ed = (step % 3 == 0) ? `ARM_D0 : (step % 3 == 1) ? `ARM_D1 :
                        (step == 2) ? `ARM_D2 : `DIS_D5;
  // load window runs from the last rise; a late fall starts a fresh load
  always @(negedge we_n_i) begin
    tf = $realtime;
    if (tf - tr > WIN) begin
      step = 0;
      ok = 1'b0;
    end
    if (!ce_n_i) al = a_i;
  end
  // data taken on the rise; short or ungated strobes do nothing
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i && $realtime - tf >= 20.0) begin
      tr = $realtime;
      if (al === ea && (dq_i === ed || (step == 2 && dq_i === `DIS_D2))) begin
        if (step == 2 && dq_i === `ARM_D2) begin
          locked = 1'b1;
          ok = 1'b1;
          step = 0;
        end else if (step == 5) begin
          locked = 1'b0;
          step = 0;
        end else step = step + 1;
      end else begin
        step = 0;
        if (!locked || ok) mem[al] = dq_i;
        else rej = rej + 1;
      end
    end
  end
endmodule // eeprom_model
`default_nettype wire

// [verification/eeprom_write_host_props.sv]
// assertions on the eeprom write controller pins
// assumes bind from the bench; one clock, async low reset
`timescale 1ns/10ps
`default_nettype none
module eeprom_write_host_props #(
  parameter [22:0] HOLDOFF_CYC = 23'h14
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_ok_i,
  input wire logic req_i,
  input wire logic [1:0] op_i,
  input wire logic lock_armed_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic ready_o,
  input wire logic lock_state_o,
  input wire logic ce_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic [15:0] a_o,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe_o
);
  logic [22:0] up_cnt;
  // cycles since reset release, saturating so it never wraps
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_cnt <= 23'h0;
    else if (up_cnt < HOLDOFF_CYC) up_cnt <= up_cnt + 23'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence take_arm;
    ready_o && req_i && op_i == 2'h1;
  endsequence
  sequence take_disarm;
    ready_o && req_i && op_i == 2'h2 && !lock_armed_i;
  endsequence
  strobe_gate_a: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
    else $error("strobe not gated");
  strobe_width_a: assert property ($fell(we_n_o) |-> !we_n_o [*5])
    else $error("strobe too short");
  bus_hold_a: assert property (!we_n_o |-> dq_oe_o && $stable(a_o) && $stable(dq_o))
    else $error("bus moved in strobe");
  supply_block_a: assert property (!supply_ok_i |-> ##[0:5] !ready_o)
    else $error("ready with supply low");
  holdoff_wait_a: assert property (ready_o |-> up_cnt >= HOLDOFF_CYC)
    else $error("ready inside holdoff");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done too long");
  busy_ready_a: assert property (busy_o |-> !ready_o)
    else $error("ready while busy");
  idle_pins_a: assert property (!busy_o && !done_o |-> we_n_o)
    else $error("strobe while idle");
  arm_lock_a: assert property (take_arm |-> ##[1:400] lock_state_o)
    else $error("arm not seen");
  disarm_lock_a: assert property (take_disarm |-> ##[1:900] !lock_state_o)
    else $error("disarm not seen");
endmodule // eeprom_write_host_props
`default_nettype wire

// [verification/tb_eeprom_write_host.sv]
// self-checking bench: controller against the behavioural eeprom
// assumes design, header, model and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_eeprom_write_host;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic supply_ok_i = 1'b1;
  logic req_i = 1'b0;
  logic lock_armed_i = 1'b0;
  logic last_i = 1'b1;
  logic [1:0] op_i = 2'h0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] data_i = 8'h00;
  wire logic busy_o, done_o, ready_o, lock_state_o, ce_n_o, oe_n_o, we_n_o, dq_oe_o;
  wire logic [15:0] a_o;
  wire logic [7:0] dq_o, dq_w;
  int failures = 0;
  int num_checks = 0;
  int seed = 71113;
  logic lk = 1'b0;
  logic [31:0] ri;
  logic [1:0] plan [7] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0};
  // released bus shows the inverse so a late sample cannot look right
  assign dq_w = dq_oe_o ? dq_o : ~dq_o;
  // load window of 100 cycles matches the model's 2000 ns window
  eeprom_write_host #(.HOLDOFF_CYC(23'h14), .LOAD_WIN_CYC(13'h0064)) dut (.clk_i, .rst_n_i,
    .supply_ok_i, .req_i, .op_i, .addr_i, .data_i, .lock_armed_i, .last_i, .busy_o,
    .done_o, .ready_o, .lock_state_o, .ce_n_o, .oe_n_o, .we_n_o, .a_o, .dq_o, .dq_oe_o);
  eeprom_model model (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .a_i(a_o),
    .dq_i(dq_w));
  initial forever #10 clk_i = ~clk_i;
  // lock view after an operation
  function automatic logic lock_after(input logic [1:0] o, input logic cur);
    return (o == 2'h1) ? 1'b1 : (o == 2'h2) ? 1'b0 : cur;
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one request: wait ready, present for one edge, wait done, let the load window lapse
  task automatic step(input logic [1:0] o);
    logic [15:0] ra;
    logic [7:0] rd;
    int n;
    ra = $random(seed) | 16'h8000;
    rd = $random(seed);
    n = 0;
    while (ready_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    op_i = o;
    addr_i = ra;
    data_i = rd;
    req_i = 1'b1;
    @(negedge clk_i);
    req_i = 1'b0;
    while (done_o !== 1'b1 && n < 8000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 8000) failures++;
    repeat (150) @(negedge clk_i);
    lk = lock_after(o, lk);
    check("lock", lock_state_o, lk);
    check("model lock", model.locked, lk);
    if (o == 2'h0) check("mem", model.mem[ra], rd);
  endtask
  // two bytes in one page load: the second is taken on the edge right after the first done
  task automatic page2;
    logic [15:0] ra0;
    logic [15:0] ra1;
    logic [7:0] rd0;
    logic [7:0] rd1;
    int n;
    ra0 = $random(seed) | 16'h8000;
    ra1 = ra0 ^ 16'h0001;
    rd0 = $random(seed);
    rd1 = $random(seed);
    n = 0;
    while (ready_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    op_i = 2'h0;
    addr_i = ra0;
    data_i = rd0;
    last_i = 1'b0;
    req_i = 1'b1;
    @(negedge clk_i);
    req_i = 1'b0;
    while (done_o !== 1'b1 && n < 8000) begin
      @(negedge clk_i);
      n++;
    end
    check("page ready", ready_o, 1'b1);
    addr_i = ra1;
    data_i = rd1;
    last_i = 1'b1;
    req_i = 1'b1;
    @(negedge clk_i);
    req_i = 1'b0;
    check("page ce_n", ce_n_o, 1'b0);
    while (done_o !== 1'b1 && n < 8000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 8000) failures++;
    repeat (150) @(negedge clk_i);
    check("page mem0", model.mem[ra0], rd0);
    check("page mem1", model.mem[ra1], rd1);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(20 * 60000);
    failures++;
    results();
  end
  initial begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    check("we_n", we_n_o, 1'b1);
    check("dq_oe", dq_oe_o, 1'b0);
    repeat (5) @(negedge clk_i);
    check("holdoff", ready_o, 1'b0);
    foreach (plan[i]) step(plan[i]);
    page2();
    // reserved op code must start nothing
    op_i = 2'h3;
    req_i = 1'b1;
    repeat (4) @(negedge clk_i);
    req_i = 1'b0;
    check("op3 busy", busy_o, 1'b0);
    check("op3 strobe", we_n_o, 1'b1);
    for (int i = 0; i < 8; i++) begin
      ri = $random(seed);
      step((ri[1:0] == 2'h3) ? 2'h0 : ri[1:0]);
    end
    supply_ok_i = 1'b0;
    repeat (8) @(negedge clk_i);
    check("supply", ready_o, 1'b0);
    supply_ok_i = 1'b1;
    step(2'h1);
    page2();
    // host reset while the part stays armed
    rst_n_i = 1'b0;
    lock_armed_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    step(2'h0);
    lock_armed_i = 1'b0;
    step(2'h2);
    step(2'h0);
    check("rejects", model.rej[15:0], 16'h0000);
    results();
  end
endmodule // tb_eeprom_write_host
bind eeprom_write_host eeprom_write_host_props #(.HOLDOFF_CYC(HOLDOFF_CYC)) props (.clk_i,
  .rst_n_i, .supply_ok_i, .req_i, .op_i, .lock_armed_i, .busy_o, .done_o, .ready_o,
  .lock_state_o, .ce_n_o, .oe_n_o, .we_n_o, .a_o, .dq_o, .dq_oe_o);
`default_nettype wire
